/* chbr_halt_ctrl.sv */
// Halt and bus-release controller sitting between a core and the bus pins.
// Assumes one-cycle phase strobes and a core that flags its last cycle.
//
// Contract
// - Run request high runs, low halts
// - Bus released low running, high halted; bus_released_o is driven low while reset is held during halt
// - Released bus floats address, data, direction
// - Memory strobe held low while halted
// - Interrupts while halted latched, served after
// - Reset while halted drives reset vector
// - Vector fetched once run request returns
// - Halt only at instruction boundary
// - Request within 100 ns halts this instruction
// - Later request runs one more instruction
// - Bus released within 470 ns of phase two
// - Opcode fetch begins every instruction; op_fetch_o pulses only on leaving halt with no reset vector pending

`timescale 1ns/10ps

module chbr_halt_ctrl
    import chbr_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Processor clock phase strobes, one cycle at each leading edge
    input wire logic phase1_i,
    input wire logic phase2_i,
    // Control pins
    input wire logic run_req_n_i,
    input wire logic cpu_rst_n_i,
    input wire logic irq_n_i,
    input wire logic nmi_n_i,
    // Core side
    input wire logic core_instr_last_i,
    input wire logic [ADDR_W-1:0] core_addr_i,
    input wire logic [DATA_W-1:0] core_data_i,
    input wire logic core_data_oe_i,
    input wire logic core_rw_i,
    input wire logic core_valid_memory_access_i,
    input wire logic irq_ack_i,
    input wire logic nmi_ack_i,
    output logic core_run_o,
    output logic op_fetch_o,
    output logic vec_fetch_o,
    output logic irq_pend_o,
    output logic nmi_pend_o,
    // Bus pins
    output logic [ADDR_W-1:0] addr_o,
    output logic addr_oe_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic rw_o,
    output logic rw_oe_o,
    output logic valid_memory_access_o,
    output logic bus_released_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    chbr_regs_s cur_reg;
    chbr_regs_s cur_next;
    logic last_now;
    logic win_open;

    // ------------------------------------------------------------------
    // Interrupt latches
    // ------------------------------------------------------------------
    chbr_int_latch u_irq_latch (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .req_n_i(irq_n_i),
        .ack_i(irq_ack_i),
        .pend_o(irq_pend_o)
    );

    chbr_int_latch u_nmi_latch (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .req_n_i(nmi_n_i),
        .ack_i(nmi_ack_i),
        .pend_o(nmi_pend_o)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        cur_next = cur_reg;
        cur_next.op_fetch = 1'b0;
        cur_next.vec_fetch = 1'b0;
        // Cycle currently under way is the last of its instruction
        last_now = phase1_i ? core_instr_last_i : cur_reg.in_last;
        // Sample window opens at the phase-one lead
        win_open = phase1_i || (cur_reg.win_cnt < HALT_WIN_CYC);
        if (phase1_i) begin
            cur_next.win_cnt = CNT_ZERO;
        end else if (cur_reg.win_cnt != CNT_SAT) begin
            cur_next.win_cnt = cur_reg.win_cnt + CNT_ONE;
        end
        case (cur_reg.state)
            ST_RUN: begin
                // Bus follows the core, one register late
                cur_next.addr = core_addr_i;
                cur_next.addr_oe = 1'b1;
                cur_next.data = core_data_i;
                cur_next.data_oe = core_data_oe_i;
                cur_next.rw = core_rw_i;
                cur_next.rw_oe = 1'b1;
                cur_next.valid_memory_access = core_valid_memory_access_i;
                cur_next.ba = 1'b0;
                cur_next.core_run = 1'b1;
                if (phase1_i && cur_reg.in_last && cur_reg.halt_at_end) begin
                    // Boundary reached: the next opcode fetch is withheld
                    cur_next.state = ST_DRAIN;
                    cur_next.core_run = 1'b0;
                    cur_next.valid_memory_access = 1'b0;
                    cur_next.in_last = 1'b0;
                    cur_next.halt_at_end = 1'b0;
                end else begin
                    if (phase1_i) begin
                        cur_next.in_last = core_instr_last_i;
                        cur_next.halt_at_end = 1'b0;
                    end
                    // Late request misses the window and waits a whole instruction
                    if (last_now && win_open && !run_req_n_i) begin
                        cur_next.halt_at_end = 1'b1;
                    end
                end
            end
            ST_DRAIN: begin
                cur_next.valid_memory_access = 1'b0;
                cur_next.core_run = 1'b0;
                if (phase2_i) begin
                    // Release one cycle after the phase-two lead, well inside the bound
                    cur_next.state = ST_HALT;
                    cur_next.ba = 1'b1;
                    cur_next.addr_oe = 1'b0;
                    cur_next.data_oe = 1'b0;
                    cur_next.rw_oe = 1'b0;
                end
            end
            ST_HALT: begin
                cur_next.valid_memory_access = 1'b0;
                cur_next.core_run = 1'b0;
                if (!cpu_rst_n_i) begin
                    cur_next.state = ST_RST_HALT;
                    cur_next.ba = 1'b0;
                    cur_next.addr = RESET_VEC;
                    cur_next.addr_oe = 1'b1;
                    cur_next.rw = RW_READ;
                    cur_next.rw_oe = 1'b1;
                    cur_next.data_oe = 1'b0;
                end else if (phase1_i && run_req_n_i) begin
                    // Pending interrupts are seen by the core from this fetch on
                    cur_next.state = ST_RUN;
                    cur_next.ba = 1'b0;
                    cur_next.core_run = 1'b1;
                    cur_next.addr_oe = 1'b1;
                    cur_next.rw_oe = 1'b1;
                    cur_next.op_fetch = !cur_reg.vec_pend;
                    cur_next.vec_fetch = cur_reg.vec_pend;
                    cur_next.vec_pend = 1'b0;
                    cur_next.in_last = 1'b0;
                    cur_next.halt_at_end = 1'b0;
                end
            end
            ST_RST_HALT: begin
                cur_next.valid_memory_access = 1'b0;
                cur_next.ba = 1'b0;
                cur_next.addr = RESET_VEC;
                cur_next.addr_oe = 1'b1;
                cur_next.rw = RW_READ;
                cur_next.rw_oe = 1'b1;
                cur_next.data_oe = 1'b0;
                cur_next.vec_pend = 1'b1;
                if (cpu_rst_n_i) begin
                    // Still halted after reset; release the bus again
                    cur_next.state = ST_HALT;
                    cur_next.ba = 1'b1;
                    cur_next.addr_oe = 1'b0;
                    cur_next.rw_oe = 1'b0;
                end
            end
            default: begin
                cur_next = REGS_RST;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            cur_reg <= REGS_RST;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign core_run_o = cur_reg.core_run;
    assign op_fetch_o = cur_reg.op_fetch;
    assign vec_fetch_o = cur_reg.vec_fetch;
    assign addr_o = cur_reg.addr;
    assign addr_oe_o = cur_reg.addr_oe;
    assign data_o = cur_reg.data;
    assign data_oe_o = cur_reg.data_oe;
    assign rw_o = cur_reg.rw;
    assign rw_oe_o = cur_reg.rw_oe;
    assign valid_memory_access_o = cur_reg.valid_memory_access;
    assign bus_released_o = cur_reg.ba;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    localparam int chk_ba_max = BA_RISE_CYC;

    default clocking chk_cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    chk_resume_runs: assert property (
        (cur_reg.state == ST_HALT) && cpu_rst_n_i && phase1_i && run_req_n_i
        |=> core_run_o && !bus_released_o)
        else $error("halt not left on run request");

    chk_ba_low_running: assert property (
        core_run_o |-> !bus_released_o)
        else $error("bus released while running");

    chk_ba_float_bus: assert property (
        bus_released_o |-> !addr_oe_o && !data_oe_o && !rw_oe_o)
        else $error("bus driven while released");

    chk_strobe_halted: assert property (
        !core_run_o |-> !valid_memory_access_o)
        else $error("memory strobe active while halted");

    chk_reset_halted: assert property (
        ((cur_reg.state == ST_HALT) || (cur_reg.state == ST_RST_HALT)) && !cpu_rst_n_i
        |=> (addr_o == RESET_VEC) && addr_oe_o && rw_o && rw_oe_o
            && !data_oe_o && !valid_memory_access_o && !bus_released_o)
        else $error("reset outputs wrong while halted");

    chk_rst_release: assert property (
        (cur_reg.state == ST_RST_HALT) && cpu_rst_n_i
        |=> bus_released_o && !addr_oe_o && !rw_oe_o && !data_oe_o)
        else $error("bus not released after halted reset");

    chk_vec_fetch: assert property (
        (cur_reg.state == ST_HALT) && cur_reg.vec_pend && cpu_rst_n_i && phase1_i
        && run_req_n_i |=> vec_fetch_o && !op_fetch_o)
        else $error("reset vector fetch missing");

    chk_halt_boundary: assert property (
        $fell(core_run_o) |-> $past(phase1_i) && $past(cur_reg.in_last))
        else $error("halt away from instruction boundary");

    chk_early_req: assert property (
        (cur_reg.state == ST_RUN) && phase1_i && core_instr_last_i && !run_req_n_i
        |=> cur_reg.halt_at_end || !core_run_o)
        else $error("early halt request not armed");

    chk_armed_halts: assert property (
        (cur_reg.state == ST_RUN) && phase1_i && cur_reg.in_last && cur_reg.halt_at_end
        |=> !core_run_o && (cur_reg.state == ST_DRAIN))
        else $error("armed halt not taken at boundary");

    chk_late_req: assert property (
        (cur_reg.state == ST_RUN) && phase1_i && cur_reg.in_last && !cur_reg.halt_at_end
        |=> core_run_o)
        else $error("halted without a timely request");

    chk_ba_rise: assert property (
        (cur_reg.state == ST_DRAIN) && phase2_i |-> ##[1:chk_ba_max] bus_released_o)
        else $error("bus release too late");

    chk_resume_fetch: assert property (
        $fell(bus_released_o) && (cur_reg.state == ST_RUN)
        |-> core_run_o && (op_fetch_o || vec_fetch_o))
        else $error("resume without fetch");

    chk_fetch_pulse: assert property (
        op_fetch_o || vec_fetch_o |=> !op_fetch_o && !vec_fetch_o)
        else $error("fetch strobe longer than one cycle");

    chk_halt_stands: assert property (
        (cur_reg.state == ST_HALT) && cpu_rst_n_i && !phase1_i
        |=> bus_released_o && !core_run_o)
        else $error("halt left without run request");

    chk_irq_kept: assert property (
        bus_released_o && irq_pend_o && !irq_ack_i |=> irq_pend_o)
        else $error("maskable request lost while halted");

    chk_nmi_kept: assert property (
        bus_released_o && nmi_pend_o && !nmi_ack_i |=> nmi_pend_o)
        else $error("non-maskable request lost while halted");

    cov_halt_entered: cover property ($rose(bus_released_o));
    cov_resumed: cover property ($fell(bus_released_o) && op_fetch_o);
    cov_reset_vector: cover property (vec_fetch_o);
    cov_irq_halted: cover property (bus_released_o && irq_pend_o);

endmodule // chbr_halt_ctrl

/* chbr_halt_model.sv */
// Model of the external halt controller and processor clock strobes.
// Assumes the bench asks for halts by level and picks early or late timing.

`timescale 1ns/10ps

module chbr_halt_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Bench commands
    input wire logic halt_req_i,
    input wire logic late_i,
    // Strobes and run request
    output logic phase1_o,
    output logic phase2_o,
    output logic instr_last_o,
    output logic run_req_n_o
);
    // ------------------------------------------------------------------
    // Six clocks per processor cycle, two cycles per instruction
    // ------------------------------------------------------------------
    logic [2:0] cnt_reg;
    logic last_reg;

    assign phase1_o = (cnt_reg == 3'h0);
    assign phase2_o = (cnt_reg == 3'h3);
    assign instr_last_o = last_reg;

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            cnt_reg <= 3'h0;
            last_reg <= 1'b0;
            run_req_n_o <= 1'b1;
        end else begin
            cnt_reg <= (cnt_reg == 3'h5) ? 3'h0 : cnt_reg + 3'h1;
            if (cnt_reg == 3'h5) begin
                last_reg <= ~last_reg;
            end
            if (!halt_req_i) begin
                run_req_n_o <= 1'b1;
            // One clock after phase one, inside 100 ns; late drops one clock after phase two
            end else if (last_reg && (late_i ? cnt_reg == 3'h3 : cnt_reg == 3'h0)) begin
                run_req_n_o <= 1'b0;
            end
        end
    end
endmodule // chbr_halt_model

/* chbr_int_latch.sv */
// Sticky latch for one active-low interrupt request.
// Assumes the core acknowledges with a one-cycle pulse when it services.

`timescale 1ns/10ps

module chbr_int_latch (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Request and acknowledge
    input wire logic req_n_i,
    input wire logic ack_i,
    // Pending flag
    output logic pend_o
);

    typedef struct packed {
        logic pend;
    } chbr_latch_s;

    chbr_latch_s cur_reg;
    chbr_latch_s cur_next;

    always_comb begin
        cur_next = cur_reg;
        // Request beats a same-cycle acknowledge, so nothing is lost
        if (!req_n_i) begin
            cur_next.pend = 1'b1;
        end else if (ack_i) begin
            cur_next.pend = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign pend_o = cur_reg.pend;

    chk_int_latched: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !req_n_i |=> pend_o)
        else $error("interrupt request not latched");

endmodule // chbr_int_latch

/* chbr_pkg.sv */
// Constants and types for the halt and bus-release controller.
// Assumes a single 25 MHz clock and phase strobes from the clock logic.

package chbr_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    // Halt request must be low this long after the phase-one lead
    localparam int HALT_WIN_NS = 100;
    // Longest time: round down, never below one cycle
    localparam int HALT_WIN_CYC_I = (HALT_WIN_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                    (HALT_WIN_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HALT_WIN_CYC = HALT_WIN_CYC_I[CNT_W-1:0];
    // Bus-released rise after the phase-two lead
    localparam int BA_RISE_NS = 470;
    localparam int BA_RISE_CYC = (BA_RISE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                 (BA_RISE_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_SAT = 4'hF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // ------------------------------------------------------------------
    // Bus values
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RESET_VEC = 16'hFFFE;
    localparam logic [ADDR_W-1:0] ADDR_RST_VAL = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST_VAL = 8'h00;
    localparam logic RW_READ = 1'b1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN,
        ST_DRAIN,
        ST_HALT,
        ST_RST_HALT
    } chbr_state_e;

    typedef struct packed {
        chbr_state_e state;
        logic [CNT_W-1:0] win_cnt;
        logic in_last;
        logic halt_at_end;
        logic vec_pend;
        logic core_run;
        logic op_fetch;
        logic vec_fetch;
        logic ba;
        logic valid_memory_access;
        logic rw;
        logic rw_oe;
        logic [ADDR_W-1:0] addr;
        logic addr_oe;
        logic [DATA_W-1:0] data;
        logic data_oe;
    } chbr_regs_s;

    localparam chbr_regs_s REGS_RST = '{
        state: ST_RUN,
        win_cnt: CNT_SAT,
        in_last: 1'b0,
        halt_at_end: 1'b0,
        vec_pend: 1'b0,
        core_run: 1'b1,
        op_fetch: 1'b0,
        vec_fetch: 1'b0,
        ba: 1'b0,
        valid_memory_access: 1'b0,
        rw: RW_READ,
        rw_oe: 1'b0,
        addr: ADDR_RST_VAL,
        addr_oe: 1'b0,
        data: DATA_RST_VAL,
        data_oe: 1'b0
    };

endpackage : chbr_pkg

/* cpu_halt_bus_release_control_test.sv */
// Self-checking bench for the halt and bus-release controller.
// Assumes the halt model drives strobes and the run request.

`timescale 1ns/10ps

module cpu_halt_bus_release_control_test;
    import chbr_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic halt_req = 1'b0;
    logic late = 1'b0;
    logic cpu_rst_n = 1'b1;
    logic irq_n = 1'b1;
    logic nmi_n = 1'b1;
    logic irq_ack = 1'b0;
    logic nmi_ack = 1'b0;
    logic phase1, phase2, instr_last, run_req_n;
    logic core_run, op_fetch, vec_fetch, irq_pend, nmi_pend;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic addr_oe, data_oe, rw, rw_oe, valid_memory_access, ba;
    localparam logic [ADDR_W-1:0] CORE_ADDR = 16'hA5C3;
    int error_cnt = 0;
    int tests_run = 0;

    chbr_halt_model u_chbr_halt_model (.clock_i(clock), .nrst_i(nrst), .halt_req_i(halt_req),
        .late_i(late), .phase1_o(phase1), .phase2_o(phase2), .instr_last_o(instr_last),
        .run_req_n_o(run_req_n));

    chbr_halt_ctrl u_chbr_halt_ctrl (.clock_i(clock), .nrst_i(nrst), .phase1_i(phase1),
        .phase2_i(phase2), .run_req_n_i(run_req_n), .cpu_rst_n_i(cpu_rst_n), .irq_n_i(irq_n),
        .nmi_n_i(nmi_n), .core_instr_last_i(instr_last), .core_addr_i(CORE_ADDR),
        .core_data_i(8'h5A), .core_data_oe_i(1'b1), .core_rw_i(1'b0),
        .core_valid_memory_access_i(1'b1),
        .irq_ack_i(irq_ack), .nmi_ack_i(nmi_ack), .core_run_o(core_run),
        .op_fetch_o(op_fetch), .vec_fetch_o(vec_fetch), .irq_pend_o(irq_pend),
        .nmi_pend_o(nmi_pend), .addr_o(addr), .addr_oe_o(addr_oe), .data_o(data),
        .data_oe_o(data_oe), .rw_o(rw), .rw_oe_o(rw_oe),
        .valid_memory_access_o(valid_memory_access),
        .bus_released_o(ba));

    initial begin
        forever #20 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            error_cnt++;
        end
    endtask

    task automatic tally_and_finish();
        $display("Counts: %0d checks, %0d mismatches", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic pick(input int sel);
        return (sel == 0) ? ba : (sel == 1) ? core_run : run_req_n;
    endfunction

    // Bounded wait, counting phase-one strobes passed on the way
    task automatic wait_sig(input int sel, input logic v, input int lim, output int p1);
        int n;
        p1 = 0;
        n = 0;
        while (pick(sel) !== v) begin
            if (n == lim) begin
                $display("CHECK FAILED wait %0d expected %b seen timeout", sel, v);
                error_cnt++;
                tally_and_finish();
            end
            if (phase1 === 1'b1) p1++;
            step(1);
            n++;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic do_halt(input logic is_late, input int exp_p1);
        int p1;
        chk("running ba", ba, 1'b0);
        chk("running addr", addr, CORE_ADDR);
        chk("running strobe", valid_memory_access, 1'b1);
        chk("running bus", {rw, data_oe, data}, {1'b0, 1'b1, 8'h5A});
        late = is_late;
        halt_req = 1'b1;
        wait_sig(2, 1'b0, 20, p1);
        wait_sig(1, 1'b0, 40, p1);
        // Early request stops at the next fetch, late one runs one more
        chk("phase1 to halt", 16'(p1), 16'(exp_p1));
        chk("halt strobe", valid_memory_access, 1'b0);
        wait_sig(0, 1'b1, 11, p1);
        chk("halt ba", ba, 1'b1);
        chk("float", {addr_oe, data_oe, rw_oe, valid_memory_access}, 4'h0);
        step(20);
        chk("halt stands", {ba, core_run}, 2'h2);
        $display("test halt late=%b done", is_late);
    endtask

    task automatic do_resume(input logic exp_vec);
        int p1;
        halt_req = 1'b0;
        wait_sig(1, 1'b1, 20, p1);
        chk("resume ba", ba, 1'b0);
        chk("resume oe", {addr_oe, rw_oe}, 2'h3);
        chk("fetch kind", {op_fetch, vec_fetch}, {~exp_vec, exp_vec});
        step(2);
        chk("resume addr", addr, CORE_ADDR);
        chk("fetch pulse", {op_fetch, vec_fetch}, 2'h0);
        $display("test resume done");
    endtask

    task automatic t_int();
        irq_n = 1'b0;
        nmi_n = 1'b0;
        step(1);
        irq_n = 1'b1;
        nmi_n = 1'b1;
        step(3);
        chk("halted pend", {irq_pend, nmi_pend}, 2'h3);
        do_resume(1'b0);
        chk("pend kept", {irq_pend, nmi_pend}, 2'h3);
        irq_ack = 1'b1;
        nmi_ack = 1'b1;
        step(1);
        irq_ack = 1'b0;
        nmi_ack = 1'b0;
        step(1);
        chk("pend clear", {irq_pend, nmi_pend}, 2'h0);
        $display("test int done");
    endtask

    task automatic t_rst();
        cpu_rst_n = 1'b0;
        step(2);
        chk("rst addr", addr, RESET_VEC);
        chk("rst drive", {addr_oe, rw, rw_oe, data_oe}, 4'hE);
        chk("rst strobe ba", {valid_memory_access, ba}, 2'h0);
        step(5);
        chk("rst hold", addr, RESET_VEC);
        cpu_rst_n = 1'b1;
        step(2);
        chk("rst off", {ba, addr_oe}, 2'h2);
        do_resume(1'b1);
        $display("test rst done");
    endtask

    initial begin
        step(3);
        nrst = 1'b1;
        step(8);
        do_halt(1'b0, 1);
        t_int();
        step(12);
        do_halt(1'b1, 3);
        t_rst();
        tally_and_finish();
    end
endmodule // cpu_halt_bus_release_control_test
